// ---- hw/epsc_pkg.sv ----
// Constants, register map and types of the strap configuration loader
package epsc_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned RST_MIN_NS     = 1000;
   localparam int unsigned RST_MIN_CYC    =
      (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  RST_CNT_MIN    = 8'(RST_MIN_CYC);
   localparam int unsigned BLINK_HZ       = 5;
   localparam int unsigned BLINK_HALF_CYC =
      1000000000 / (CLK_PERIOD_NS * BLINK_HZ * 2);
   localparam logic [9:0]  IDX_ADVERT     = 10'h004;
   localparam logic [9:0]  IDX_PHY_CTL    = 10'h019;
   localparam logic [9:0]  IDX_STATUS     = 10'h01F;
   localparam logic [9:0]  IDX_REG_CTL    = 10'h0D0;
   localparam int unsigned CTL_MDIX_EN    = 15;
   localparam int unsigned CTL_MDIX_FORCE = 14;
   localparam int unsigned CTL_LED_MODE   = 5;
   localparam int unsigned REG_PD_BIT     = 15;
   localparam int unsigned ADV_LSB        = 5;
   localparam logic [15:0] ADV_BASE       = 16'h0001;
   localparam logic [3:0]  ADV_FULL       = 4'hF;
   localparam logic [3:0]  ADV_HALF       = 4'h5;
   localparam logic [4:0]  DEF_ADDR       = 5'h01;
   localparam logic        DEF_DUPLEX     = 1'b1;
   localparam logic        DEF_LED        = 1'b1;
   localparam logic        DEF_MDIX       = 1'b1;
   localparam logic        DEF_RMII       = 1'b0;
   localparam int unsigned ST_DUPLEX      = 5;
   localparam int unsigned ST_LED         = 6;
   localparam int unsigned ST_MDIX        = 7;
   localparam int unsigned ST_RMII        = 8;
   localparam int unsigned ST_SHORT       = 9;
   localparam int unsigned NUM_PADS       = 16;
   localparam int unsigned PAD_LED        = 3;
   localparam int unsigned PAD_RX_DV      = 5;
   localparam int unsigned PAD_CRS        = 6;
   localparam int unsigned PAD_RX_ER      = 7;
   localparam int unsigned PAD_COL        = 8;
   localparam int unsigned PAD_RXD0       = 9;
   typedef enum logic [2:0] {
      PH_RESET = 3'b001,
      PH_LOAD  = 3'b010,
      PH_RUN   = 3'b100
   } epsc_phase_e;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } epsc_bus_e;
endpackage

// ---- hw/epsc_link_if.sv ----
// Interface between the loader core, strap latch and LED driver
`timescale 1ns/10ps
`default_nettype none
interface epsc_link_if;
   logic       sample;
   logic [4:0] addr;
   logic       duplex;
   logic       led;
   logic       mdix;
   logic       rmii;
   logic       led_mode;
   logic       link_up;
   logic       activity;
   logic       led_on;
   modport latch (input sample, output addr, duplex, led, mdix, rmii);
   modport led_drv (input led_mode, link_up, activity, output led_on);
   modport core (output sample, led_mode, link_up, activity,
                 input addr, duplex, led, mdix, rmii, led_on);
endinterface
`default_nettype wire

// ---- hw/epsc_strap_latch.sv ----
// Strap sampling latch
`timescale 1ns/10ps
`default_nettype none
module epsc_strap_latch
   import epsc_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                sys_rst_i,
   input  wire logic                clk_en_i,
   input  wire logic [NUM_PADS-1:0] pad_i,
   epsc_link_if.latch               lnk
);
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lnk.addr   <= DEF_ADDR;
         lnk.duplex <= DEF_DUPLEX;
         lnk.led    <= DEF_LED;
         lnk.mdix   <= DEF_MDIX;
         lnk.rmii   <= DEF_RMII;
      end else if (clk_en_i && lnk.sample) begin
         lnk.addr   <= {pad_i[PAD_RXD0+3:PAD_RXD0], pad_i[PAD_COL]};
         lnk.duplex <= pad_i[PAD_LED];
         lnk.led    <= pad_i[PAD_CRS];
         lnk.mdix   <= pad_i[PAD_RX_ER];
         lnk.rmii   <= pad_i[PAD_RX_DV];
      end
   end
endmodule
`default_nettype wire

// ---- hw/epsc_led_drv.sv ----
// Link LED driver with activity blink
`timescale 1ns/10ps
`default_nettype none
module epsc_led_drv
   import epsc_pkg::*;
#(
   parameter int unsigned HALF_CYC = BLINK_HALF_CYC
)(
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic clk_en_i,
   epsc_link_if.led_drv lnk
);
   logic [23:0] cnt_q;
   logic        phase_q;

   // Blink half-period timer
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q   <= 24'h000000;
         phase_q <= 1'b0;
      end else if (clk_en_i) begin
         if (cnt_q >= 24'(HALF_CYC - 1)) begin
            cnt_q   <= 24'h000000;
            phase_q <= ~phase_q;
         end else begin
            cnt_q <= cnt_q + 24'h000001;
         end
      end
   end

   // Mode 1 link only, mode 2 blinks on activity
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lnk.led_on <= 1'b0;
      end else if (clk_en_i) begin
         if (lnk.led_mode) begin
            lnk.led_on <= lnk.link_up;
         end else begin
            lnk.led_on <= lnk.link_up & (~lnk.activity | phase_q);
         end
      end
   end
endmodule
`default_nettype wire

// ---- hw/epsc_top.sv ----
// Strap configuration loader top with register slave and pad control
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module epsc_top
   import epsc_pkg::*;
#(
   parameter int unsigned BLINK_HALF_CYC_P = BLINK_HALF_CYC
)(
   input  wire logic                clk_i,
   input  wire logic                sys_rst_i,
   input  wire logic                clk_en_i,
   input  wire logic                phy_rst_n_i,
   input  wire logic [11:0]         avs_address_i,
   input  wire logic                avs_read_i,
   input  wire logic                avs_write_i,
   input  wire logic [3:0]          avs_byteenable_i,
   input  wire logic [31:0]         avs_writedata_i,
   output logic      [31:0]         avs_readdata_o,
   output logic                     avs_waitrequest_o,
   input  wire logic [NUM_PADS-1:0] pad_i,
   output logic      [NUM_PADS-1:0] pad_o,
   output logic      [NUM_PADS-1:0] pad_oe_n_o,
   input  wire logic [NUM_PADS-1:0] core_out_i,
   input  wire logic [NUM_PADS-1:0] core_oe_i,
   input  wire logic                link_up_i,
   input  wire logic                activity_i,
   output logic      [4:0]          station_addr_o,
   output logic                     full_duplex_o,
   output logic                     rmii_mode_o,
   output logic                     mdix_en_o,
   output logic                     force_mdix_o,
   output logic                     led_mode_o,
   output logic                     regulator_pd_o,
   output logic      [15:0]         advert_o,
   output logic                     cfg_ready_o
);

   epsc_phase_e phase_q;
   epsc_phase_e phase_d;
   logic        ready_q;
   epsc_bus_e   bus_q;
   logic        sample_q;
   logic [15:0] phy_ctl_q;
   logic [15:0] reg_ctl_q;
   logic [15:0] advert_q;
   logic [7:0]  rst_cnt_q;
   logic        short_q;
   logic        waitreq_q;
   logic [31:0] rdata_q;
   logic [NUM_PADS-1:0] pad_q;
   logic [NUM_PADS-1:0] oe_n_q;
   logic        wr_fire;
   logic        run;
   logic [9:0]  idx;

   epsc_link_if lnk ();

   assign lnk.sample   = sample_q;
   assign lnk.led_mode = phy_ctl_q[CTL_LED_MODE];
   assign lnk.link_up  = link_up_i;
   assign lnk.activity = activity_i;

   assign idx     = avs_address_i[11:2];
   assign wr_fire = (bus_q == BUS_ACK) && avs_write_i;
   assign run     = (phase_q == PH_RUN);

   epsc_strap_latch u_latch (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .clk_en_i  (clk_en_i),
      .pad_i     (pad_i),
      .lnk       (lnk.latch)
   );

   epsc_led_drv #(
      .HALF_CYC (BLINK_HALF_CYC_P)
   ) u_led (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .clk_en_i  (clk_en_i),
      .lnk       (lnk.led_drv)
   );

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] wdata,
      input logic [3:0]  be
   );
      logic [15:0] res;
      res = old;
      if (be[0]) begin
         res[7:0] = wdata[7:0];
      end
      if (be[1]) begin
         res[15:8] = wdata[15:8];
      end
      return res;
   endfunction

   // Advertisement bits from the duplex strap
   function automatic logic [15:0] advert_init(input logic duplex);
      logic [15:0] res;
      res = ADV_BASE;
      res[ADV_LSB+3:ADV_LSB] = duplex ? ADV_FULL : ADV_HALF;
      return res;
   endfunction

   // Read multiplexer
   function automatic logic [31:0] rd_mux(input logic [9:0] i);
      logic [31:0] res;
      res = 32'h00000000;
      case (i)
         IDX_ADVERT:  res[15:0] = advert_q;
         IDX_PHY_CTL: res[15:0] = phy_ctl_q;
         IDX_REG_CTL: res[15:0] = reg_ctl_q;
         IDX_STATUS: begin
            res[4:0]       = lnk.addr;
            res[ST_DUPLEX] = lnk.duplex;
            res[ST_LED]    = lnk.led;
            res[ST_MDIX]   = lnk.mdix;
            res[ST_RMII]   = lnk.rmii;
            res[ST_SHORT]  = short_q;
         end
         default: res = 32'h00000000;
      endcase
      return res;
   endfunction

   // Next phase of reset, load and run
   always_comb begin
      phase_d = phase_q;
      if (!phy_rst_n_i) begin
         phase_d = PH_RESET;
      end else begin
         case (phase_q)
            PH_RESET: begin
               phase_d = PH_LOAD;
            end
            PH_LOAD: begin
               phase_d = PH_RUN;
            end
            PH_RUN: begin
               phase_d = PH_RUN;
            end
            default: begin
               phase_d = PH_RESET;
            end
         endcase
      end
   end

   // Reset, load and run phases
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         phase_q <= PH_RESET;
      end else if (clk_en_i) begin
         phase_q <= phase_d;
      end
   end

   // Ready flag registered alongside the phase
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ready_q <= 1'b0;
      end else if (clk_en_i) begin
         ready_q <= (phase_d == PH_RUN);
      end
   end

   // Strap sampling window, also once after power-on
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sample_q <= 1'b1;
      end else if (clk_en_i) begin
         sample_q <= !phy_rst_n_i;
      end
   end

   // Reset pulse width measure and short-pulse flag
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rst_cnt_q <= 8'h00;
      end else if (clk_en_i) begin
         if (!phy_rst_n_i) begin
            if (rst_cnt_q < RST_CNT_MIN) begin
               rst_cnt_q <= rst_cnt_q + 8'h01;
            end
         end else begin
            rst_cnt_q <= 8'h00;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         short_q <= 1'b0;
      end else if (clk_en_i) begin
         if (phy_rst_n_i && (rst_cnt_q != 8'h00) &&
             (rst_cnt_q < RST_CNT_MIN)) begin
            short_q <= 1'b1;
         end else if (wr_fire && (idx == IDX_STATUS) &&
                      avs_byteenable_i[1] && avs_writedata_i[ST_SHORT]) begin
            short_q <= 1'b0;
         end
      end
   end

   // PHY control register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         phy_ctl_q <= 16'h0000;
         phy_ctl_q[CTL_LED_MODE] <= DEF_LED;
         phy_ctl_q[CTL_MDIX_EN]  <= DEF_MDIX;
      end else if (clk_en_i) begin
         if (phase_q == PH_LOAD) begin
            phy_ctl_q <= 16'h0000;
            phy_ctl_q[CTL_LED_MODE] <= lnk.led;
            phy_ctl_q[CTL_MDIX_EN]  <= lnk.mdix;
         end else if (run && wr_fire && (idx == IDX_PHY_CTL)) begin
            phy_ctl_q <= merge16(phy_ctl_q, avs_writedata_i,
                                 avs_byteenable_i);
         end
      end
   end

   // Regulator control register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_ctl_q <= 16'h0000;
      end else if (clk_en_i) begin
         if (phase_q == PH_RESET) begin
            reg_ctl_q <= 16'h0000;
         end else if (run && wr_fire && (idx == IDX_REG_CTL)) begin
            reg_ctl_q <= merge16(reg_ctl_q, avs_writedata_i,
                                 avs_byteenable_i);
         end
      end
   end

   // Auto-negotiation advertisement register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         advert_q <= advert_init(DEF_DUPLEX);
      end else if (clk_en_i) begin
         if (phase_q == PH_LOAD) begin
            advert_q <= advert_init(lnk.duplex);
         end else if (run && wr_fire && (idx == IDX_ADVERT)) begin
            advert_q <= merge16(advert_q, avs_writedata_i,
                                avs_byteenable_i);
         end
      end
   end

   // Bus handshake, one wait cycle per access
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bus_q     <= BUS_IDLE;
         waitreq_q <= 1'b1;
      end else if (clk_en_i) begin
         case (bus_q)
            BUS_IDLE: begin
               if (avs_read_i || avs_write_i) begin
                  bus_q     <= BUS_ACK;
                  waitreq_q <= 1'b0;
               end
            end
            BUS_ACK: begin
               bus_q     <= BUS_IDLE;
               waitreq_q <= 1'b1;
            end
            default: begin
               bus_q     <= BUS_IDLE;
               waitreq_q <= 1'b1;
            end
         endcase
      end
   end

   // Read data capture
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_q <= 32'h00000000;
      end else if (clk_en_i) begin
         if ((bus_q == BUS_IDLE) && avs_read_i) begin
            rdata_q <= rd_mux(idx);
         end
      end
   end

   // Pad drive: all released in reset, functional afterwards
   for (genvar k = 0; k < NUM_PADS; k++) begin : g_pad
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            pad_q[k]  <= 1'b0;
            oe_n_q[k] <= 1'b1;
         end else if (clk_en_i) begin
            if (!run || !phy_rst_n_i) begin
               pad_q[k]  <= 1'b0;
               oe_n_q[k] <= 1'b1;
            end else if (k == PAD_LED) begin
               pad_q[k]  <= lnk.led_on;
               oe_n_q[k] <= 1'b0;
            end else begin
               pad_q[k]  <= core_out_i[k];
               oe_n_q[k] <= ~core_oe_i[k];
            end
         end
      end
   end

   assign avs_readdata_o    = rdata_q;
   assign avs_waitrequest_o = waitreq_q;
   assign pad_o             = pad_q;
   assign pad_oe_n_o        = oe_n_q;
   assign station_addr_o    = lnk.addr;
   assign full_duplex_o     = lnk.duplex;
   assign rmii_mode_o       = lnk.rmii;
   assign mdix_en_o         = phy_ctl_q[CTL_MDIX_EN];
   assign force_mdix_o      = phy_ctl_q[CTL_MDIX_FORCE];
   assign led_mode_o        = phy_ctl_q[CTL_LED_MODE];
   assign regulator_pd_o    = reg_ctl_q[REG_PD_BIT];
   assign advert_o          = advert_q;
   assign cfg_ready_o       = ready_q;

endmodule
`default_nettype wire

// ---- test/epsc_board_model.sv ----
// Board reset source and pad pull levels for the strap loader
`timescale 1ns/10ps
`default_nettype none
module epsc_board_model
   import epsc_pkg::*;
#(
   parameter int unsigned LOW_CYC = 50
)(
   input  wire logic                clk_i,
   input  wire logic                go_i,
   input  wire logic [NUM_PADS-1:0] res_val_i,
   input  wire logic [NUM_PADS-1:0] res_en_i,
   input  wire logic [NUM_PADS-1:0] pad_o_i,
   input  wire logic [NUM_PADS-1:0] pad_oe_n_i,
   output logic                     phy_rst_n_o,
   output logic      [NUM_PADS-1:0] pad_i_o
);
   localparam logic [15:0] PULL_UP  = 16'h01CC;
   localparam logic [15:0] HAS_PULL = 16'h1FEF;
   logic [7:0] cnt_q = 8'h00;
   logic       tgl_q = 1'b0;
   always_ff @(posedge clk_i) begin
      tgl_q <= !tgl_q;
      if (go_i) begin
         cnt_q <= 8'(LOW_CYC);
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
   assign phy_rst_n_o = (cnt_q == 8'h00);
   // Driven pad, else fitted resistor, else pull, else a floating toggle
   always_comb begin
      for (int k = 0; k < NUM_PADS; k++) begin
         pad_i_o[k] = !pad_oe_n_i[k] ? pad_o_i[k] : res_en_i[k] ? res_val_i[k]
                    : HAS_PULL[k] ? PULL_UP[k] : tgl_q;
      end
   end
endmodule
`default_nettype wire

// ---- test/epsc_monitor.sv ----
// Port checker of the strap loader top
`timescale 1ns/10ps
`default_nettype none
module epsc_monitor
   import epsc_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                sys_rst_i,
   input  wire logic                phy_rst_n_i,
   input  wire logic [11:0]         avs_address_i,
   input  wire logic                avs_read_i,
   input  wire logic                avs_write_i,
   input  wire logic [3:0]          avs_byteenable_i,
   input  wire logic [31:0]         avs_writedata_i,
   input  wire logic                avs_waitrequest_o,
   input  wire logic [NUM_PADS-1:0] pad_o,
   input  wire logic [NUM_PADS-1:0] pad_oe_n_o,
   input  wire logic [NUM_PADS-1:0] core_oe_i,
   input  wire logic                link_up_i,
   input  wire logic [4:0]          station_addr_o,
   input  wire logic                full_duplex_o,
   input  wire logic                rmii_mode_o,
   input  wire logic                led_mode_o,
   input  wire logic                regulator_pd_o,
   input  wire logic [15:0]         advert_o,
   input  wire logic                cfg_ready_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   hiz_reset_a: assert property (!phy_rst_n_i [*2] |=> pad_oe_n_o == 16'hFFFF)
      else $error("pads driven during reset");
   strap_hold_a: assert property (cfg_ready_o && $past(cfg_ready_o)
      |-> $stable({station_addr_o, full_duplex_o, rmii_mode_o}))
      else $error("latched straps changed");
   advert_load_a: assert property ($rose(cfg_ready_o)
      |-> advert_o[8:5] == (full_duplex_o ? ADV_FULL : ADV_HALF))
      else $error("advertisement not from duplex strap");
   wait_pulse_a: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o)
      else $error("no bus answer");
   reg_pd_a: assert property (avs_write_i && !avs_waitrequest_o && cfg_ready_o
      && avs_address_i == 12'h340 && avs_byteenable_i[1]
      |=> regulator_pd_o == $past(avs_writedata_i[15]))
      else $error("regulator bit not written");
   reg_clear_a: assert property (!phy_rst_n_i |-> ##2 !regulator_pd_o)
      else $error("regulator bit kept over reset");
   link_led_out_a: assert property (cfg_ready_o && $past(cfg_ready_o, 3) && led_mode_o
      && $past(led_mode_o) && $past(led_mode_o, 2)
      |-> pad_o[PAD_LED] == $past(link_up_i, 2))
      else $error("link led does not follow link");
   func_pad_a: assert property (cfg_ready_o && $past(cfg_ready_o)
      |-> (pad_oe_n_o | 16'h0008) == (~$past(core_oe_i) | 16'h0008))
      else $error("pad enable not functional");
endmodule
`default_nettype wire

// ---- test/ethernet_phy_strap_config_tb_top.sv ----
// Testbench of the strap configuration loader
`timescale 1ns/10ps
`default_nettype none
module ethernet_phy_strap_config_tb_top
   import epsc_pkg::*;
;
   logic        clk_i, sys_rst_i, phy_rst_n, go, avs_read_i, avs_write_i;
   logic        avs_waitrequest_o, link_up_i, activity_i, full_duplex_o, rmii_mode_o;
   logic        mdix_en_o, force_mdix_o, led_mode_o, regulator_pd_o, cfg_ready_o;
   logic [11:0] avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic [15:0] pad_i, pad_o, pad_oe_n_o, core_out_i, core_oe_i, advert_o, res_val, res_en;
   logic [4:0]  station_addr_o;
   int          miscompares, total_checks, k;
   epsc_top #(.BLINK_HALF_CYC_P(4)) i_epsc_top (.clk_i, .sys_rst_i, .clk_en_i(1'b1),
      .phy_rst_n_i(phy_rst_n), .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_byteenable_i(4'h3), .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
      .pad_i, .pad_o, .pad_oe_n_o, .core_out_i, .core_oe_i, .link_up_i, .activity_i,
      .station_addr_o, .full_duplex_o, .rmii_mode_o, .mdix_en_o, .force_mdix_o,
      .led_mode_o, .regulator_pd_o, .advert_o, .cfg_ready_o);
   epsc_board_model i_epsc_board_model (.clk_i, .go_i(go), .res_val_i(res_val),
      .res_en_i(res_en), .pad_o_i(pad_o), .pad_oe_n_i(pad_oe_n_o),
      .phy_rst_n_o(phy_rst_n), .pad_i_o(pad_i));
   task automatic summarize;
      $display("Checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [31:0] cfg();
      return {22'h0, force_mdix_o, rmii_mode_o, mdix_en_o, led_mode_o, full_duplex_o,
              station_addr_o};
   endfunction
   task automatic bus(input logic we, input logic [11:0] a, input logic [15:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      avs_address_i   <= a;
      avs_writedata_i <= {16'h0000, wd};
      avs_write_i     <= we;
      avs_read_i      <= !we;
      do begin
         @(posedge clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      rd = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
      if (n >= 50) begin
         miscompares++;
         summarize();
      end
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      while (!(phy_rst_n === 1'b1 && cfg_ready_o === 1'b1) && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 300) begin
         miscompares++;
         summarize();
      end
      repeat (3) @(posedge clk_i);
   endtask
   task automatic phy_reset;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk("pad_oe_n", {16'h0, pad_oe_n_o}, 32'h0000_FFFF);
      wait_ready();
   endtask
   task automatic led_ones(output int c);
      c = 0;
      repeat (3) @(posedge clk_i);
      repeat (24) begin
         @(posedge clk_i);
         c += (pad_o[PAD_LED] === 1'b1) ? 1 : 0;
      end
   endtask
   task automatic t_defaults;
      wait_ready();
      chk("cfg", cfg(), 32'h0000_00E1);
      chk("advert", {16'h0, advert_o}, 32'h0000_01E1);
      bus(1'b0, 12'h07C, 16'h0000);
      chk("status", rd, 32'h0000_00E1);
      bus(1'b0, 12'h064, 16'h0000);
      chk("phy_control", rd, 32'h0000_8020);
      bus(1'b0, 12'h340, 16'h0000);
      chk("regulator_control", rd, 32'h0);
      bus(1'b0, 12'h200, 16'h0000);
      chk("unmapped", rd, 32'h0);
      $display("Test defaults done");
   endtask
   task automatic t_straps;
      res_en  <= 16'h1FE8;
      res_val <= 16'h1A20;
      phy_reset();
      chk("cfg", cfg(), 32'h0000_011A);
      chk("advert", {16'h0, advert_o}, 32'h0000_00A1);
      res_en     <= 16'h0000;
      core_oe_i  <= 16'hFFFF;
      core_out_i <= 16'hA5A5;
      link_up_i  <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk("cfg hold", cfg(), 32'h0000_011A);
      chk("pad_oe_n", {16'h0, pad_oe_n_o | 16'h0008}, 32'h0000_0008);
      chk("pad_o", {16'h0, pad_o}, 32'h0000_A5AD);
      $display("Test straps done");
   endtask
   task automatic t_regs;
      bus(1'b1, 12'h340, 16'h8000);
      bus(1'b0, 12'h340, 16'h0000);
      chk("regulator_control", rd, 32'h0000_8000);
      chk("regulator_pd", {31'h0, regulator_pd_o}, 32'h1);
      bus(1'b1, 12'h07C, 16'h01FF);
      bus(1'b0, 12'h07C, 16'h0000);
      chk("status", rd, 32'h0000_011A);
      activity_i <= 1'b1;
      bus(1'b1, 12'h064, 16'h0020);
      led_ones(k);
      chk("led mode1", k, 24);
      bus(1'b1, 12'h064, 16'h0000);
      chk("mdix", {31'h0, mdix_en_o}, 32'h0);
      led_ones(k);
      chk("led mode2", {31'h0, k > 0 && k < 24}, 32'h1);
      phy_reset();
      chk("regulator_pd", {31'h0, regulator_pd_o}, 32'h0);
      chk("cfg", cfg(), 32'h0000_00E1);
      bus(1'b0, 12'h064, 16'h0000);
      chk("phy_control", rd, 32'h0000_8020);
      $display("Test registers done");
   endtask
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = !clk_i;
   end
   initial begin
      miscompares = 0;
      total_checks = 0;
      sys_rst_i = 1'b1;
      go = 1'b0;
      avs_read_i = 1'b0;
      avs_write_i = 1'b0;
      avs_address_i = 12'h000;
      avs_writedata_i = 32'h0;
      link_up_i = 1'b0;
      activity_i = 1'b0;
      core_out_i = 16'h0000;
      core_oe_i = 16'h0000;
      res_val = 16'h0000;
      res_en = 16'h0000;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_defaults();
      t_straps();
      t_regs();
      summarize();
   end
endmodule
bind epsc_top epsc_monitor i_epsc_monitor (.clk_i, .sys_rst_i, .phy_rst_n_i,
   .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_writedata_i,
   .avs_waitrequest_o, .pad_o, .pad_oe_n_o, .core_oe_i, .link_up_i, .station_addr_o,
   .full_duplex_o, .rmii_mode_o, .led_mode_o, .regulator_pd_o, .advert_o, .cfg_ready_o);
`default_nettype wire
